// *** lcd_decoder_pkg.sv ***
// lcd_decoder_pkg: shared constants and types of the instruction decoder
// assumes: no surroundings; pure definitions
package lcd_decoder_pkg;

  // bus map, word offsets as byte addresses
  localparam logic [3:0] OFS_INSTR  = 4'h0;
  localparam logic [3:0] OFS_DATA   = 4'h4;
  localparam logic [3:0] OFS_MODE   = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hC;

  // address counter width and ram sizes
  localparam int AC_W        = 7;
  localparam int TEXT_DEPTH  = 128;
  localparam int GLYPH_DEPTH = 64;
  localparam int ICON_DEPTH  = 16;

  // text line wrap points
  localparam logic [6:0] LINE2_START = 7'h40;
  localparam logic [6:0] ONE_LAST    = 7'h4F;
  localparam logic [6:0] TWO_L1_LAST = 7'h27;
  localparam logic [6:0] TWO_L2_LAST = 7'h67;
  localparam logic [4:0] FOUR_COL_LAST = 5'h13;

  // scroll quantity saturation
  localparam logic [5:0] SCROLL_MAX  = 6'h30;

  // busy time, 39 us at 25 MHz
  localparam int CLK_HZ        = 25000000;
  localparam int EXEC_NS       = 39000;
  localparam int EXEC_CYCLES   = (EXEC_NS * (CLK_HZ / 1000000) + 999) / 1000;

  // reset values
  localparam logic RST_BUS_WIDTH = 1'b1;
  localparam logic RST_TWO_LINE  = 1'b1;
  localparam logic RST_STEP_UP   = 1'b1;

  typedef enum logic [1:0] {
    RAM_TEXT  = 2'b00,
    RAM_GLYPH = 2'b01,
    RAM_ICON  = 2'b10
  } ram_sel_t;

  typedef enum logic [1:0] {
    LINES_ONE  = 2'b00,
    LINES_TWO  = 2'b01,
    LINES_FOUR = 2'b10
  } line_mode_t;

  // display-side settings carried together
  typedef struct packed {
    logic       bus_width_bit;
    logic       two_line;
    logic       four_row_bit;
    logic       extended_page_bit;
    logic       blink_attr_on;
    logic       slow_clock_bit;
    logic [3:0] line_scroll_enables;
    logic [5:0] scroll_amount;
  } lcd_config_t;

endpackage

// *** lcd_clock_divider.sv ***
// lcd_clock_divider: one-cycle enable at clk/1, /2 or /4
// assumes: single clock, synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module lcd_clock_divider (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // ratio select: 0 full, 1 half, 2 quarter
  input  wire logic [1:0] ratio_i,
  // enable out
  output logic            tick_o
);
  logic [1:0] count;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= 2'h0;
    end else begin
      count <= count + 2'h1;
    end
  end

  always_comb begin
    case (ratio_i)
      2'h1:    tick_o = (count[0] == 1'b1);
      2'h2:    tick_o = (count == 2'h3);
      default: tick_o = 1'b1;
    endcase
  end
endmodule
`default_nettype wire

// *** lcd_address_stepper.sv ***
// lcd_address_stepper: next address counter value after a step
// assumes: combinational only, used by the decoder
`timescale 1ns/100ps
`default_nettype none
module lcd_address_stepper (
  // current state
  input  wire logic [6:0] ac_i,
  input  wire logic [1:0] ram_i,
  input  wire logic [1:0] lines_i,
  input  wire logic       up_i,
  // result
  output logic [6:0]      next_ac_o
);
  always_comb begin
    next_ac_o = up_i ? ac_i + 7'h01 : ac_i - 7'h01;
    if (ram_i == lcd_decoder_pkg::RAM_GLYPH) begin
      next_ac_o = {1'b0, next_ac_o[5:0]};
    end else if (ram_i == lcd_decoder_pkg::RAM_ICON) begin
      next_ac_o = {3'h0, next_ac_o[3:0]};
    end else if (lines_i == lcd_decoder_pkg::LINES_ONE) begin
      if (up_i && ac_i == lcd_decoder_pkg::ONE_LAST) begin
        next_ac_o = 7'h00;
      end else if (!up_i && ac_i == 7'h00) begin
        next_ac_o = lcd_decoder_pkg::ONE_LAST;
      end
    end else if (lines_i == lcd_decoder_pkg::LINES_TWO) begin
      if (up_i && ac_i == lcd_decoder_pkg::TWO_L1_LAST) begin
        next_ac_o = lcd_decoder_pkg::LINE2_START;
      end else if (up_i && ac_i == lcd_decoder_pkg::TWO_L2_LAST) begin
        next_ac_o = 7'h00;
      end else if (!up_i && ac_i == lcd_decoder_pkg::LINE2_START) begin
        next_ac_o = lcd_decoder_pkg::TWO_L1_LAST;
      end else if (!up_i && ac_i == 7'h00) begin
        next_ac_o = lcd_decoder_pkg::TWO_L2_LAST;
      end
    end else begin
      if (up_i && ac_i[4:0] == lcd_decoder_pkg::FOUR_COL_LAST) begin
        next_ac_o = {ac_i[6:5] + 2'h1, 5'h00};
      end else if (!up_i && ac_i[4:0] == 5'h00) begin
        next_ac_o = {ac_i[6:5] - 2'h1, lcd_decoder_pkg::FOUR_COL_LAST};
      end
    end
  end
endmodule
`default_nettype wire

// *** lcd_instruction_decoder.sv ***
// lcd_instruction_decoder: instruction decoder, address counter and rams
// assumes: classic wishbone master on clk_i; host pacing via busy bit
//
// Functional notes
// - page 0 shift code: cursor left/right steps counter, display shifts.
// - two-line mode: cursor goes to line two after digit 40.
// - four-line mode: cursor goes to next line after each digit 20.
// - display shift affects all lines, address counter untouched.
// - page 1 scroll-enable loads four per-line enables from low nibble.
// - bus width bit: set 8-bit, clear 4-bit with two nibble writes.
// - line bit picks one or two lines unless four-row bit set.
// - extended page bit gates extended set, icon address, scroll, blink.
// - blink enable makes glyph and icon bytes blink by top two bits.
// - low power with expansion pin low divides clock by four or two.
// - low power frame rate drops to 5/6; host avoids display shift.
// - page 0 code 01 loads 6-bit glyph address, selects glyph ram.
// - page 1 code 01 loads 4-bit icon address, selects icon ram.
// - page 0 top bit loads 7-bit text address, selects text ram.
// - valid text addresses follow line mode ranges.
// - page 1 top bit loads scroll amount, 48 when upper bits set.
// - status read returns busy in bit 7 and counter below.
// - data write stores byte to selected ram, counter steps.
// - read without prior address set returns stale first byte.
// - cursor shift reloads text read register like address set.
// - entry-mode direction bit selects increment or decrement.
`timescale 1ns/100ps
`default_nettype none
module lcd_instruction_decoder #(
  parameter int EXEC_CYCLES = lcd_decoder_pkg::EXEC_CYCLES
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // board strap
  input  wire logic        expansion_driver_pin_i,
  // display-side state
  output lcd_decoder_pkg::lcd_config_t cfg_o,
  output logic [1:0]       line_mode_o,
  output logic [6:0]       display_offset_o,
  output logic             blink_glyph_o,
  output logic             slow_tick_o
);
  initial begin
    if (EXEC_CYCLES < 1 || EXEC_CYCLES > 65535) begin
      $error("EXEC_CYCLES out of range");
    end
  end

  lcd_decoder_pkg::lcd_config_t cfg;
  logic [6:0]  address_counter;
  logic [1:0]  ram_sel;
  logic        step_up;
  logic        display_shift_on;
  logic [6:0]  display_offset;
  logic        read_valid;
  logic [7:0]  read_latch;
  logic [15:0] busy_count;
  logic        busy_indicator;
  logic        nibble_high_done;
  logic [3:0]  nibble_high;
  logic [7:0]  text_ram  [lcd_decoder_pkg::TEXT_DEPTH];
  logic [7:0]  glyph_ram [lcd_decoder_pkg::GLYPH_DEPTH];
  logic [7:0]  icon_ram  [lcd_decoder_pkg::ICON_DEPTH];
  logic [1:0]  line_mode;
  logic [6:0]  stepped_ac;
  logic [6:0]  next_ac;
  logic        tick;
  logic [1:0]  ratio;
  logic [1:0]  ram_sel_next;

  // bus strobes
  logic access;
  logic wr_word;
  logic rd_word;
  assign access  = cyc_i && stb_i && !ack_o;
  assign wr_word = access && we_i && sel_i[0];
  assign rd_word = access && !we_i;

  // byte assembly in 4-bit mode
  logic       byte_ready;
  logic [7:0] host_byte;
  logic       is_instr;
  logic       is_data;
  assign is_instr = (adr_i == lcd_decoder_pkg::OFS_INSTR);
  assign is_data  = (adr_i == lcd_decoder_pkg::OFS_DATA);
  assign byte_ready = wr_word && (is_instr || is_data) &&
                      (cfg.bus_width_bit || nibble_high_done);
  assign host_byte  = cfg.bus_width_bit ? dat_i[7:0] : {nibble_high, dat_i[3:0]};

  // data read pairing in 4-bit mode
  logic rd_data_byte;
  logic rd_nibble_low;
  assign rd_data_byte = rd_word && is_data && (cfg.bus_width_bit || rd_nibble_low);

  logic       instr_wr;
  logic       data_wr;
  assign instr_wr = byte_ready && is_instr;
  assign data_wr  = byte_ready && is_data;

  function automatic logic [1:0] lines_of(input lcd_decoder_pkg::lcd_config_t c);
    if (c.four_row_bit) begin
      lines_of = lcd_decoder_pkg::LINES_FOUR;
    end else if (c.two_line) begin
      lines_of = lcd_decoder_pkg::LINES_TWO;
    end else begin
      lines_of = lcd_decoder_pkg::LINES_ONE;
    end
  endfunction

  assign line_mode = lines_of(cfg);

  lcd_address_stepper stepper (
    .ac_i      (address_counter),
    .ram_i     (ram_sel),
    .lines_i   (line_mode),
    .up_i      (step_up),
    .next_ac_o (stepped_ac)
  );

  always_comb begin
    ratio = 2'h0;
    if (cfg.slow_clock_bit && !expansion_driver_pin_i) begin
      ratio = (line_mode == lcd_decoder_pkg::LINES_ONE) ? 2'h2 : 2'h1;
    end
  end

  lcd_clock_divider divider (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ratio_i (ratio),
    .tick_o  (tick)
  );

  // nibble phase tracking
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nibble_high_done <= 1'b0;
      nibble_high      <= 4'h0;
      rd_nibble_low    <= 1'b0;
    end else if (cfg.bus_width_bit) begin
      nibble_high_done <= 1'b0;
      rd_nibble_low    <= 1'b0;
    end else begin
      if (wr_word && (is_instr || is_data)) begin
        nibble_high_done <= !nibble_high_done;
        nibble_high      <= dat_i[3:0];
      end
      if (rd_word && (is_instr || is_data)) begin
        rd_nibble_low <= !rd_nibble_low;
      end
    end
  end

  // instruction decode and address counter
  always_comb begin
    next_ac = address_counter;
    if (instr_wr) begin
      if (host_byte[7]) begin
        if (!cfg.extended_page_bit) begin
          next_ac = host_byte[6:0];
        end
      end else if (host_byte[6]) begin
        if (cfg.extended_page_bit) begin
          next_ac = {3'h0, host_byte[3:0]};
        end else begin
          next_ac = {1'b0, host_byte[5:0]};
        end
      end else if (host_byte[7:4] == 4'h1 && !cfg.extended_page_bit && !host_byte[3]) begin
        next_ac = host_byte[2] ? stepped_ac_dir(1'b1) : stepped_ac_dir(1'b0);
      end else if (host_byte[7:1] == 7'h01) begin
        next_ac = 7'h00;
      end else if (host_byte == 8'h01) begin
        next_ac = 7'h00;
      end
    end else if (data_wr || rd_data_byte) begin
      next_ac = stepped_ac;
    end
  end

  // direction override for cursor moves
  logic       cursor_dir;
  logic [6:0] cursor_ac;
  assign cursor_dir = host_byte[2];
  lcd_address_stepper cursor_stepper (
    .ac_i      (address_counter),
    .ram_i     (ram_sel),
    .lines_i   (line_mode),
    .up_i      (cursor_dir),
    .next_ac_o (cursor_ac)
  );

  function automatic logic [6:0] stepped_ac_dir(input logic dir);
    stepped_ac_dir = cursor_ac;
  endfunction

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      address_counter <= 7'h00;
    end else begin
      address_counter <= next_ac;
    end
  end

  // configuration and selection state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg               <= '0;
      cfg.bus_width_bit <= lcd_decoder_pkg::RST_BUS_WIDTH;
      cfg.two_line      <= lcd_decoder_pkg::RST_TWO_LINE;
      ram_sel           <= lcd_decoder_pkg::RAM_TEXT;
      step_up           <= lcd_decoder_pkg::RST_STEP_UP;
      display_shift_on  <= 1'b0;
    end else if (instr_wr) begin
      if (host_byte[7:5] == 3'b001) begin
        // page bit held until next function set
        cfg.bus_width_bit     <= host_byte[4];
        cfg.two_line          <= host_byte[3];
        cfg.extended_page_bit <= host_byte[2];
        // blink and low power only on page 1
        if (host_byte[2]) begin
          cfg.blink_attr_on  <= host_byte[1];
          cfg.slow_clock_bit <= host_byte[0];
        end
      end else if (host_byte[7]) begin
        if (!cfg.extended_page_bit) begin
          ram_sel <= lcd_decoder_pkg::RAM_TEXT;
        end
        if (cfg.extended_page_bit) begin
          cfg.scroll_amount <= (host_byte[5:4] == 2'b11) ? lcd_decoder_pkg::SCROLL_MAX
                                                         : host_byte[5:0];
        end
      end else if (host_byte[6]) begin
        ram_sel <= cfg.extended_page_bit ? lcd_decoder_pkg::RAM_ICON : lcd_decoder_pkg::RAM_GLYPH;
      end else if (host_byte[7:4] == 4'h1) begin
        if (cfg.extended_page_bit) begin
          cfg.line_scroll_enables <= host_byte[3:0];
        end
      end else if (host_byte[7:3] == 5'b00001) begin
        if (cfg.extended_page_bit) begin
          cfg.four_row_bit <= host_byte[0];
        end
      end else if (host_byte[7:2] == 6'b000001) begin
        step_up          <= host_byte[1];
        display_shift_on <= host_byte[0];
      end else if (host_byte == 8'h01) begin
        step_up <= 1'b1;
        ram_sel <= lcd_decoder_pkg::RAM_TEXT;
      end
    end
  end

  // display shift offset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      display_offset <= 7'h00;
    end else if (instr_wr && host_byte[7:1] <= 7'h01 && host_byte != 8'h00) begin
      display_offset <= 7'h00;
    end else if (instr_wr && host_byte[7:4] == 4'h1 && host_byte[3] &&
                 !cfg.extended_page_bit) begin
      display_offset <= host_byte[2] ? display_offset - 7'h01 : display_offset + 7'h01;
    end else if (data_wr && display_shift_on && ram_sel == lcd_decoder_pkg::RAM_TEXT) begin
      display_offset <= step_up ? display_offset + 7'h01 : display_offset - 7'h01;
    end
  end

  // ram writes
  always_ff @(posedge clk_i) begin
    if (data_wr) begin
      if (ram_sel == lcd_decoder_pkg::RAM_GLYPH) begin
        glyph_ram[address_counter[5:0]] <= host_byte;
      end else if (ram_sel == lcd_decoder_pkg::RAM_ICON) begin
        icon_ram[address_counter[3:0]] <= host_byte;
      end else begin
        // text write only inside line range
        if (text_addr_ok(address_counter, line_mode)) begin
          text_ram[address_counter] <= host_byte;
        end
      end
    end
  end

  function automatic logic text_addr_ok(input logic [6:0] a, input logic [1:0] m);
    if (m == lcd_decoder_pkg::LINES_ONE) begin
      text_addr_ok = (a <= lcd_decoder_pkg::ONE_LAST);
    end else if (m == lcd_decoder_pkg::LINES_TWO) begin
      text_addr_ok = (a[5:0] <= lcd_decoder_pkg::TWO_L1_LAST[5:0]);
    end else begin
      text_addr_ok = (a[4:0] <= lcd_decoder_pkg::FOUR_COL_LAST);
    end
  endfunction

  // read latch: refreshed by address set, cursor shift or data read
  logic reload;
  assign reload = instr_wr && (host_byte[7] || host_byte[6] ||
                  (host_byte[7:3] == 5'b00010 && !cfg.extended_page_bit));
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      read_valid <= 1'b0;
      read_latch <= 8'h00;
    end else if (reload || rd_data_byte) begin
      read_valid <= 1'b1;
      if (ram_sel_next == lcd_decoder_pkg::RAM_GLYPH) begin
        read_latch <= glyph_ram[next_ac[5:0]];
      end else if (ram_sel_next == lcd_decoder_pkg::RAM_ICON) begin
        read_latch <= icon_ram[next_ac[3:0]];
      end else begin
        read_latch <= text_ram[next_ac];
      end
    end
  end

  always_comb begin
    ram_sel_next = ram_sel;
    if (instr_wr && host_byte[7] && !cfg.extended_page_bit) begin
      ram_sel_next = lcd_decoder_pkg::RAM_TEXT;
    end else if (instr_wr && host_byte[6]) begin
      ram_sel_next = cfg.extended_page_bit ? lcd_decoder_pkg::RAM_ICON
                                           : lcd_decoder_pkg::RAM_GLYPH;
    end
  end

  // busy timer, slowed by low power tick
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_count <= 16'h0000;
    end else if (instr_wr || data_wr) begin
      busy_count <= 16'(EXEC_CYCLES);
    end else if (busy_count != 16'h0000 && tick) begin
      busy_count <= busy_count - 16'h0001;
    end
  end
  assign busy_indicator = (busy_count != 16'h0000);

  // blink phase from slow tick
  logic [15:0] blink_count;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      blink_count <= 16'h0000;
    end else if (tick) begin
      blink_count <= blink_count + 16'h0001;
    end
  end

  // bus answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= access;
      if (rd_word) begin
        if (is_instr) begin
          // busy in bit 7, counter below
          dat_o <= {24'h0, busy_indicator, address_counter};
        end else if (is_data) begin
          dat_o <= {24'h0, read_latch};
        end else if (adr_i == lcd_decoder_pkg::OFS_MODE) begin
          dat_o <= {16'h0, cfg};
        end else if (adr_i == lcd_decoder_pkg::OFS_STATUS) begin
          dat_o <= {22'h0, read_valid, display_shift_on, step_up, ram_sel,
                    line_mode, expansion_driver_pin_i, nibble_high_done, busy_indicator};
        end else begin
          dat_o <= 32'h0000_0000;
        end
      end
    end
  end

  // outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_o            <= '0;
      line_mode_o      <= lcd_decoder_pkg::LINES_ONE;
      display_offset_o <= 7'h00;
      blink_glyph_o    <= 1'b0;
    end else begin
      cfg_o            <= cfg;
      line_mode_o      <= line_mode;
      display_offset_o <= display_offset;
      blink_glyph_o    <= cfg.blink_attr_on && blink_count[15];
    end
  end
  assign slow_tick_o = tick;
endmodule
`default_nettype wire

// *** lcd_decoder_sva.sv ***
// lcd_decoder_sva: bus and mode checks on the decoder ports
// assumes: bound to lcd_instruction_decoder, one clock domain
`timescale 1ns/100ps
`default_nettype none
module lcd_decoder_sva #(
  parameter int EXEC_CYCLES = 4
) (
  // clock and reset
  input wire logic                         clk_i,
  input wire logic                         rst_i,
  // bus
  input wire logic                         cyc_i,
  input wire logic                         stb_i,
  input wire logic                         ack_o,
  // strap and display side
  input wire logic                         expansion_driver_pin_i,
  input wire lcd_decoder_pkg::lcd_config_t cfg_o,
  input wire logic [1:0]                   line_mode_o,
  input wire logic                         blink_glyph_o,
  input wire logic                         slow_tick_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // divider ratio conditions
  wire logic full_c = !cfg_o.slow_clock_bit || expansion_driver_pin_i;
  wire logic half_c = !full_c && (line_mode_o != lcd_decoder_pkg::LINES_ONE);
  wire logic quart_c = !full_c && (line_mode_o == lcd_decoder_pkg::LINES_ONE);
  sequence s_taken; cyc_i && stb_i && !ack_o; endsequence
  sequence s_quart_run; quart_c [*5]; endsequence
  property p_ack_resp; s_taken |=> ack_o; endproperty
  property p_ack_pulse; ack_o |=> !ack_o; endproperty
  property p_mode_four; cfg_o.four_row_bit && $past(cfg_o.four_row_bit)
    |-> line_mode_o == lcd_decoder_pkg::LINES_FOUR; endproperty
  property p_mode_two; !cfg_o.four_row_bit && cfg_o.two_line && $past(cfg_o) == cfg_o
    |-> line_mode_o == lcd_decoder_pkg::LINES_TWO; endproperty
  property p_full; full_c && $past(full_c) && $past(full_c, 2) |-> slow_tick_o; endproperty
  property p_half; half_c && $past(half_c) && $past(half_c, 2)
    |-> slow_tick_o != $past(slow_tick_o); endproperty
  property p_quarter; s_quart_run ##0 slow_tick_o
    |-> !$past(slow_tick_o) && !$past(slow_tick_o, 2) && !$past(slow_tick_o, 3); endproperty
  property p_scroll_cap; cfg_o.scroll_amount <= lcd_decoder_pkg::SCROLL_MAX; endproperty
  property p_page_gate; !cfg_o.extended_page_bit && !$past(cfg_o.extended_page_bit)
    |-> $stable(cfg_o.line_scroll_enables) && $stable(cfg_o.scroll_amount); endproperty
  property p_blink; !cfg_o.blink_attr_on && !$past(cfg_o.blink_attr_on) |-> !blink_glyph_o;
  endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("no ack after request");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_mode_four: assert property (p_mode_four) else $error("four-row not four lines");
  a_mode_two: assert property (p_mode_two) else $error("line bit not two lines");
  a_full: assert property (p_full) else $error("tick missing at full rate");
  a_half: assert property (p_half) else $error("tick not halved");
  a_quarter: assert property (p_quarter) else $error("tick not quartered");
  a_scroll_cap: assert property (p_scroll_cap) else $error("scroll above 48");
  a_page_gate: assert property (p_page_gate) else $error("page 1 item changed on page 0");
  a_blink: assert property (p_blink) else $error("blink without enable");
endmodule
bind lcd_instruction_decoder lcd_decoder_sva #(
  .EXEC_CYCLES(EXEC_CYCLES)
) lcd_decoder_sva_i (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .cyc_i(cyc_i),
  .stb_i(stb_i),
  .ack_o(ack_o),
  .expansion_driver_pin_i(expansion_driver_pin_i),
  .cfg_o(cfg_o),
  .line_mode_o(line_mode_o),
  .blink_glyph_o(blink_glyph_o),
  .slow_tick_o(slow_tick_o)
);
`default_nettype wire

// *** lcd_host_model.sv ***
// lcd_host_model: host issuing instruction and data bytes over wishbone
// assumes: decoder answers with ack; busy polled through status byte
`timescale 1ns/100ps
`default_nettype none
module lcd_host_model (
  // clock and answer
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  // request
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [3:0]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      dat_o
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 4'hF;
    sel_o = 4'h0;
    dat_o = 32'hFFFFFFFF;
  end
  // one classic cycle
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= 4'hF;
    dat_o <= d;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    adr_o <= ~a;
    dat_o <= ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] q);
    logic [31:0] r;
    bus(1'b0, a, 32'h00000000, r);
    q = r[7:0];
  endtask
  task automatic send(input logic [3:0] a, input logic [7:0] b, input logic poll);
    logic [31:0] r;
    bus(1'b1, a, {24'h000000, b}, r);
    if (poll) begin
      do bus(1'b0, lcd_decoder_pkg::OFS_INSTR, 32'h00000000, r); while (r[7] !== 1'b0);
    end else begin
      repeat (12) @(posedge clk_i);
    end
  endtask
  task automatic nib(input logic [3:0] a, input logic [7:0] b);
    logic [31:0] r;
    bus(1'b1, a, {28'h0000000, b[7:4]}, r);
    bus(1'b1, a, {28'h0000000, b[3:0]}, r);
    repeat (12) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// *** char_lcd_instruction_decoder_test.sv ***
// char_lcd_instruction_decoder_test: self-checking run of the decoder
// assumes: lcd_host_model drives the bus; checker bound separately
`timescale 1ns/100ps
`default_nettype none
module char_lcd_instruction_decoder_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic pin = 1'b1;
  logic cyc, stb, we, ack, blink, tick;
  logic [3:0] adr, sel;
  logic [31:0] dat_w, dat_r;
  lcd_decoder_pkg::lcd_config_t cfg;
  logic [1:0] lmode;
  logic [6:0] offset;
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #20 clk_i = ~clk_i;
  lcd_instruction_decoder #(.EXEC_CYCLES(4)) lcd_instruction_decoder_i (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack), .expansion_driver_pin_i(pin),
    .cfg_o(cfg), .line_mode_o(lmode), .display_offset_o(offset), .blink_glyph_o(blink),
    .slow_tick_o(tick));
  lcd_host_model lcd_host_model_i (
    .clk_i(clk_i), .ack_i(ack), .dat_i(dat_r), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .sel_o(sel), .dat_o(dat_w));
  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] q;
    lcd_host_model_i.rd(a, q);
    chk(q, e);
  endtask
  task automatic ac(input logic [6:0] e);
    rdc(lcd_decoder_pkg::OFS_INSTR, {1'b0, e});
  endtask
  task automatic ins(input logic [7:0] b);
    lcd_host_model_i.send(lcd_decoder_pkg::OFS_INSTR, b, 1'b1);
  endtask
  task automatic dat(input logic [7:0] b);
    lcd_host_model_i.send(lcd_decoder_pkg::OFS_DATA, b, 1'b1);
  endtask
  task automatic ticks(input logic [7:0] e);
    logic [7:0] n;
    n = 8'h00;
    repeat (4) @(posedge clk_i);
    repeat (8) begin
      @(posedge clk_i);
      n = n + {7'h00, tick};
    end
    chk(n, e);
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    ac(7'h00);
    chk({7'h00, cfg.bus_width_bit}, 8'h01);
    chk({6'h00, lmode}, 8'h01);
    ins(8'hC0);
    dat(8'h3C);
    ins(8'hA7);
    dat(8'h5A);
    ac(7'h40);
    ins(8'hA7);
    rdc(lcd_decoder_pkg::OFS_DATA, 8'h5A);
    ins(8'hA7);
    ins(8'h14);
    ac(7'h40);
    rdc(lcd_decoder_pkg::OFS_DATA, 8'h3C);
    ac(7'h41);
    ins(8'h10);
    ac(7'h40);
    ins(8'h18);
    chk({1'b0, offset}, 8'h01);
    ins(8'h1C);
    chk({1'b0, offset}, 8'h00);
    ac(7'h40);
    ins(8'h04);
    ins(8'h85);
    dat(8'h11);
    ac(7'h04);
    ins(8'h06);
    ins(8'h45);
    dat(8'h77);
    ac(7'h06);
    ins(8'h45);
    rdc(lcd_decoder_pkg::OFS_DATA, 8'h77);
    ins(8'h3E);
    chk({7'h00, cfg.extended_page_bit}, 8'h01);
    chk({7'h00, cfg.blink_attr_on}, 8'h01);
    ins(8'h13);
    chk({4'h0, cfg.line_scroll_enables}, 8'h03);
    ins(8'h1C);
    chk({4'h0, cfg.line_scroll_enables}, 8'h0C);
    ac(7'h06);
    ins(8'hAF);
    chk({2'h0, cfg.scroll_amount}, 8'h2F);
    ins(8'hF5);
    chk({2'h0, cfg.scroll_amount}, 8'h30);
    ins(8'h7A);
    dat(8'h99);
    ac(7'h0B);
    ins(8'h7A);
    rdc(lcd_decoder_pkg::OFS_DATA, 8'h99);
    ins(8'h09);
    chk({6'h00, lmode}, 8'h02);
    ins(8'h38);
    chk({7'h00, cfg.extended_page_bit}, 8'h00);
    ins(8'h93);
    dat(8'h22);
    ac(7'h20);
    ins(8'h3C);
    ins(8'h08);
    ins(8'h30);
    chk({6'h00, lmode}, 8'h00);
    pin <= 1'b0;
    ins(8'h35);
    ticks(8'h02);
    pin <= 1'b1;
    ticks(8'h08);
    pin <= 1'b0;
    ins(8'h3D);
    ticks(8'h04);
    ins(8'h3C);
    ticks(8'h08);
    lcd_host_model_i.send(lcd_decoder_pkg::OFS_INSTR, 8'h28, 1'b0);
    chk({7'h00, cfg.bus_width_bit}, 8'h00);
    lcd_host_model_i.nib(lcd_decoder_pkg::OFS_INSTR, 8'h93);
    lcd_host_model_i.nib(lcd_decoder_pkg::OFS_INSTR, 8'h38);
    ac(7'h13);
    rdc(4'h2, 8'h00);
    summarize();
  end
endmodule
`default_nettype wire
